// ===== src/fdet_mon_consts.vh
// constants for the fast-detect threshold and signal-monitor block
// assumes an axi4-lite slave in one clock domain, byte offsets = index * 4
// Operation
// - a 13-bit upper threshold is split into a low byte and a five-bit high part and compared to the magnitude.
// - a 13-bit lower threshold is split into a low byte and a five-bit high part and compared to the magnitude.
// - a 16-bit dwell counter loads from the two dwell bytes and counts time below the lower threshold.
// - with fast detect enabled and force clear, the alarm pin is released to 0 only after the magnitude stays below the lower threshold for the full dwell.
// - with the sync mode bit at 1 only the next valid sysref edge resynchronises the monitor, later ones are ignored.
// - the sync mode bit clears itself once it has been used, acting as a one-shot arm.
// - each monitor window lasts the 24-bit period in output clock cycles, with bit 0 ignored.
// - when force is set the alarm pin shows the force value instead of the comparator.
// - the frame counter increments each time the period counter expires, except when a sysref hit resynchronises the monitor in the same cycle.
// - writing 1 to the update bit latches the selected result into readback and the bit clears itself.
`ifndef FDET_MON_CONSTS_VH
`define FDET_MON_CONSTS_VH
`define IDX_FD_CTRL 12'h245
`define IDX_UTH_LO 12'h247
`define IDX_UTH_HI 12'h248
`define IDX_LTH_LO 12'h249
`define IDX_LTH_HI 12'h24a
`define IDX_DW_LO 12'h24b
`define IDX_DW_HI 12'h24c
`define IDX_SYNC 12'h26f
`define IDX_MONCTL 12'h270
`define IDX_PER0 12'h271
`define IDX_PER1 12'h272
`define IDX_PER2 12'h273
`define IDX_STCTL 12'h274
`define IDX_ST0 12'h275
`define IDX_ST1 12'h276
`define IDX_ST2 12'h277
`define IDX_FRAME 12'h278
`define IDX_IRQ_STAT 12'h280
`define IDX_IRQ_MASK 12'h281
`define RST_PER0 8'h80
`define RST_SEL 3'h1
`define SEL_PEAK 3'h1
`define BIT_FD_EN 0
`define BIT_FORCE_VAL 2
`define BIT_FORCE 3
`define BIT_PEAK_EN 1
`define BIT_SYNC 0
`define BIT_UPDATE 4
`define IRQ_W 3
`define IRQ_ALARM_RISE 0
`define IRQ_PERIOD 1
`define IRQ_SYNCED 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== src/fdet_mon.v
// fast-detect comparator with dwell release and a peak signal monitor, one channel
// assumes magnitude and sysref edge are synchronous to clk_sys, axi4-lite master in same domain
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "fdet_mon_consts.vh"
module fdet_mon #(
  parameter MAG_W = 13,
  parameter DWELL_W = 16,
  parameter PER_W = 24
) (
  // clock, reset, enable
  input wire clk_sys,
  input wire rst_n,
  input wire clkEn,
  // converter side
  input wire [MAG_W-1:0] magnitude,
  input wire sysrefEdge,
  input wire sysrefEnabled,
  // alarm and interrupt
  output reg thresholdAlarmPin,
  output reg irq,
  // axi4-lite write address
  input wire [13:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [13:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
reg [7:0] fdCtrl_q;
reg [12:0] upperTh_q, lowerTh_q;
reg [15:0] dwell_q;
reg syncArm_q, peakEn_q;
reg [23:0] period_q;
reg [2:0] resultSel_q;
reg [19:0] result_q;
reg [7:0] frameCnt_q;
reg [`IRQ_W-1:0] irqStat_q, irqMask_q;
reg [15:0] dwellCnt_q;
reg alarmRaw_q;
reg [PER_W-1:0] perCnt_q;
reg [MAG_W-1:0] peak_q, peakHeld_q;
reg [13:0] awAddr_q;
reg [31:0] wData_q;
reg [3:0] wStrb_q;
reg awHave_q, wHave_q;

////////////////////////////////////////////////////////////////////////////////
// fast detect comparator
wire aboveUpper = magnitude > upperTh_q;
wire belowLower = magnitude < lowerTh_q;
wire fdEn = fdCtrl_q[`BIT_FD_EN];
wire alarmSet = fdEn && aboveUpper;
wire dwellDone = belowLower && (dwellCnt_q == 16'h0000);
wire alarmNext = fdEn && (alarmSet || (alarmRaw_q && !dwellDone));
wire pinNext = fdCtrl_q[`BIT_FORCE] ? fdCtrl_q[`BIT_FORCE_VAL] : alarmNext;

always @(posedge clk_sys) begin
  if (!rst_n) begin
    alarmRaw_q <= 1'b0;
    dwellCnt_q <= 16'h0000;
    thresholdAlarmPin <= 1'b0;
  end else if (clkEn) begin
    alarmRaw_q <= alarmNext;
    thresholdAlarmPin <= pinNext;
    if (!belowLower || alarmSet)
      dwellCnt_q <= dwell_q;
    else if (dwellCnt_q != 16'h0000)
      dwellCnt_q <= dwellCnt_q - 16'h0001;
  end
end

////////////////////////////////////////////////////////////////////////////////
// signal monitor: period, frame count, peak
wire [PER_W-1:0] perLen = {period_q[PER_W-1:1], 1'b0};
wire perExpire = (perCnt_q + {{(PER_W-1){1'b0}}, 1'b1}) >= perLen;
wire syncHit = syncArm_q && sysrefEdge && sysrefEnabled;

always @(posedge clk_sys) begin
  if (!rst_n) begin
    perCnt_q <= {PER_W{1'b0}};
    frameCnt_q <= 8'h00;
    peak_q <= {MAG_W{1'b0}};
    peakHeld_q <= {MAG_W{1'b0}};
  end else if (clkEn) begin
    if (syncHit) begin
      perCnt_q <= {PER_W{1'b0}};
      peak_q <= {MAG_W{1'b0}};
    end else if (perExpire) begin
      perCnt_q <= {PER_W{1'b0}};
      frameCnt_q <= frameCnt_q + 8'h01;
      peakHeld_q <= peakEn_q ? peak_q : peakHeld_q;
      peak_q <= {MAG_W{1'b0}};
    end else begin
      perCnt_q <= perCnt_q + {{(PER_W-1){1'b0}}, 1'b1};
      if (peakEn_q && magnitude > peak_q)
        peak_q <= magnitude;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave and registers
wire awGo = s_axi_awvalid && s_axi_awready;
wire wGo = s_axi_wvalid && s_axi_wready;
wire [13:0] wrA = awGo ? s_axi_awaddr : awAddr_q;
wire [31:0] wrD = wGo ? s_axi_wdata : wData_q;
wire [3:0] wrS = wGo ? s_axi_wstrb : wStrb_q;
wire wrDo = (awHave_q || awGo) && (wHave_q || wGo) && !s_axi_bvalid;
wire [11:0] wrIdx = wrA[13:2];
wire [11:0] rdIdx = s_axi_araddr[13:2];
wire wrOk = (wrIdx == `IDX_FD_CTRL) || (wrIdx == `IDX_UTH_LO) || (wrIdx == `IDX_UTH_HI) ||
  (wrIdx == `IDX_LTH_LO) || (wrIdx == `IDX_LTH_HI) || (wrIdx == `IDX_DW_LO) || (wrIdx == `IDX_DW_HI) ||
  (wrIdx == `IDX_SYNC) || (wrIdx == `IDX_MONCTL) || (wrIdx == `IDX_PER0) || (wrIdx == `IDX_PER1) ||
  (wrIdx == `IDX_PER2) || (wrIdx == `IDX_STCTL) || (wrIdx == `IDX_IRQ_STAT) || (wrIdx == `IDX_IRQ_MASK);
wire wb = wrDo && wrS[0];
wire [`IRQ_W-1:0] irqEv;
assign irqEv[`IRQ_ALARM_RISE] = alarmNext && !alarmRaw_q;
assign irqEv[`IRQ_PERIOD] = perExpire && !syncHit;
assign irqEv[`IRQ_SYNCED] = syncHit;
wire updReq = wb && (wrIdx == `IDX_STCTL) && wrD[`BIT_UPDATE];

always @(posedge clk_sys) begin
  if (!rst_n) begin
    fdCtrl_q <= 8'h00;
    upperTh_q <= 13'h0000;
    lowerTh_q <= 13'h0000;
    dwell_q <= 16'h0000;
    syncArm_q <= 1'b0;
    peakEn_q <= 1'b0;
    period_q <= {16'h0000, `RST_PER0};
    resultSel_q <= `RST_SEL;
    result_q <= 20'h00000;
    irqStat_q <= {`IRQ_W{1'b0}};
    irqMask_q <= {`IRQ_W{1'b0}};
    irq <= 1'b0;
    awHave_q <= 1'b0;
    wHave_q <= 1'b0;
    awAddr_q <= 14'h0000;
    wData_q <= 32'h00000000;
    wStrb_q <= 4'h0;
    s_axi_awready <= 1'b0;
    s_axi_wready <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `RESP_OKAY;
    s_axi_arready <= 1'b0;
    s_axi_rvalid <= 1'b0;
    s_axi_rresp <= `RESP_OKAY;
    s_axi_rdata <= 32'h00000000;
  end else if (clkEn) begin
    // write channel capture
    // no new address or data while a response is still pending
    s_axi_awready <= !awHave_q && !awGo && !wrDo && !s_axi_bvalid;
    s_axi_wready <= !wHave_q && !wGo && !wrDo && !s_axi_bvalid;
    if (awGo) begin
      awAddr_q <= s_axi_awaddr;
    end
    if (wGo) begin
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end
    awHave_q <= wrDo ? 1'b0 : (awHave_q || awGo);
    wHave_q <= wrDo ? 1'b0 : (wHave_q || wGo);
    if (wrDo) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
    if (wb) begin
      case (wrIdx)
        `IDX_FD_CTRL: fdCtrl_q <= {4'h0, wrD[3:2], 1'b0, wrD[0]};
        `IDX_UTH_LO: upperTh_q[7:0] <= wrD[7:0];
        `IDX_UTH_HI: upperTh_q[12:8] <= wrD[4:0];
        `IDX_LTH_LO: lowerTh_q[7:0] <= wrD[7:0];
        `IDX_LTH_HI: lowerTh_q[12:8] <= wrD[4:0];
        `IDX_DW_LO: dwell_q[7:0] <= wrD[7:0];
        `IDX_DW_HI: dwell_q[15:8] <= wrD[7:0];
        `IDX_MONCTL: peakEn_q <= wrD[`BIT_PEAK_EN];
        `IDX_PER0: period_q[7:0] <= wrD[7:0];
        `IDX_PER1: period_q[15:8] <= wrD[7:0];
        `IDX_PER2: period_q[23:16] <= wrD[7:0];
        `IDX_STCTL: resultSel_q <= wrD[2:0];
        `IDX_IRQ_MASK: irqMask_q <= wrD[`IRQ_W-1:0];
        default: ;
      endcase
    end
    // one-shot arm, the sysref hit wins over a rewrite in the same cycle
    if (syncHit)
      syncArm_q <= 1'b0;
    else if (wb && wrIdx == `IDX_SYNC)
      syncArm_q <= wrD[`BIT_SYNC];
    if (updReq)
      result_q <= (resultSel_q == `SEL_PEAK) ? {{(20-MAG_W){1'b0}}, peakHeld_q} : 20'h00000;
    // sticky status, set wins over write-one clear
    irqStat_q <= (irqStat_q & ~((wb && wrIdx == `IDX_IRQ_STAT) ? wrD[`IRQ_W-1:0] : {`IRQ_W{1'b0}})) | irqEv;
    irq <= |(irqStat_q & irqMask_q);
    // read channel
    if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (rdIdx)
        `IDX_FD_CTRL: s_axi_rdata <= {24'h000000, fdCtrl_q};
        `IDX_UTH_LO: s_axi_rdata <= {24'h000000, upperTh_q[7:0]};
        `IDX_UTH_HI: s_axi_rdata <= {27'h0000000, upperTh_q[12:8]};
        `IDX_LTH_LO: s_axi_rdata <= {24'h000000, lowerTh_q[7:0]};
        `IDX_LTH_HI: s_axi_rdata <= {27'h0000000, lowerTh_q[12:8]};
        `IDX_DW_LO: s_axi_rdata <= {24'h000000, dwell_q[7:0]};
        `IDX_DW_HI: s_axi_rdata <= {24'h000000, dwell_q[15:8]};
        `IDX_SYNC: s_axi_rdata <= {31'h00000000, syncArm_q};
        `IDX_MONCTL: s_axi_rdata <= {30'h00000000, peakEn_q, 1'b0};
        `IDX_PER0: s_axi_rdata <= {24'h000000, period_q[7:0]};
        `IDX_PER1: s_axi_rdata <= {24'h000000, period_q[15:8]};
        `IDX_PER2: s_axi_rdata <= {24'h000000, period_q[23:16]};
        `IDX_STCTL: s_axi_rdata <= {29'h00000000, resultSel_q};
        `IDX_ST0: s_axi_rdata <= {24'h000000, result_q[7:0]};
        `IDX_ST1: s_axi_rdata <= {24'h000000, result_q[15:8]};
        `IDX_ST2: s_axi_rdata <= {28'h0000000, result_q[19:16]};
        `IDX_FRAME: s_axi_rdata <= {24'h000000, frameCnt_q};
        `IDX_IRQ_STAT: s_axi_rdata <= {29'h00000000, irqStat_q};
        `IDX_IRQ_MASK: s_axi_rdata <= {29'h00000000, irqMask_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
end

endmodule // fdet_mon

// ===== bench/fdet_mon_properties.sv
// checker on the fdet_mon ports: bus handshakes and reset quiet
// assumes clkEn held high while it watches
`timescale 1ns/100ps
module fdet_mon_properties (
  // clock and reset
  input logic clk_sys,
  input logic rst_n,
  // alarm and interrupt
  input logic thresholdAlarmPin,
  input logic irq,
  // axi4-lite handshakes
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  sequence sWrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sRdTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_B_AFTER_TAKE: assert property (sWrTake |=> s_axi_bvalid) else $error("no bvalid");
  AST_R_AFTER_TAKE: assert property (sRdTake |=> s_axi_rvalid) else $error("no rvalid");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid lost");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid lost");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("awready early");
  AST_READY_BACK: assert property ($rose(rst_n) |-> ##[1:3] s_axi_arready) else $error("no ready");
  AST_RST_QUIET: assert property (disable iff (1'b0) !rst_n |=> !thresholdAlarmPin && !irq && !s_axi_bvalid)
    else $error("reset not quiet");
endmodule // fdet_mon_properties

// ===== bench/agc_watch.sv
// partner: gain-control logic counting alarm assertions
// assumes the alarm pin is registered on clk_sys
`timescale 1ns/100ps
module agc_watch (
  // clock and reset
  input logic clk_sys,
  input logic rst_n,
  // alarm pin and rise count
  input logic alarm,
  output logic [7:0] nRise
);
  logic last_q;
  always @(posedge clk_sys) begin
    last_q <= rst_n & alarm;
    if (!rst_n) nRise <= 8'h00;
    else if (alarm && !last_q) nRise <= nRise + 8'h01;
  end
endmodule // agc_watch

// ===== bench/fdet_mon_tb.sv
// bench for fdet_mon: register table loop, then alarm, force, monitor, sync, peak
// assumes agc_watch and fdet_mon_properties
`timescale 1ns/100ps
`include "fdet_mon_consts.vh"
module fdet_mon_tb;
  logic clk_sys = 0, rst_n = 0, sysrefEdge = 0, sysrefEnabled = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [12:0] magnitude = 0;
  logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, v;
  logic [1:0] r;
  logic [7:0] f[3], d;
  wire thresholdAlarmPin, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] nRise;
  int n_fail = 0, checked = 0, i;
  logic [35:0] tbl[9] = '{36'h248_00_ff_1f, 36'h249_00_ff_ff, 36'h24a_00_ff_1f, 36'h24b_00_ff_ff,
    36'h24c_00_ff_ff, 36'h270_00_ff_02, 36'h271_80_54_54, 36'h272_00_a5_a5, 36'h273_00_5a_5a};
  logic [19:0] cfg[10] = '{20'h247_64, 20'h248_01, 20'h249_32, 20'h24a_01, 20'h24b_03, 20'h24c_00,
    20'h271_03, 20'h272_00, 20'h273_00, 20'h281_01};
  fdet_mon i_dut (.clk_sys, .rst_n, .clkEn(1'b1), .magnitude, .sysrefEdge, .sysrefEnabled, .thresholdAlarmPin,
    .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  agc_watch i_agc (.clk_sys, .rst_n, .alarm(thresholdAlarmPin), .nRise);
  always #4 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("fails=%0d checks=%0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task hang(input bit done);
    if (!done) begin
      n_fail++;
      give_verdict;
    end
  endtask
  task wr(input [11:0] a, input [7:0] dat);
    bit done;
    @(posedge clk_sys);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= {24'h0, dat};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    done = 0;
    for (int k = 0; k < 99 && !done; k++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 0;
        done = 1;
      end
    end
    hang(done);
  endtask
  task rd(input [11:0] a);
    bit done;
    @(posedge clk_sys);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    done = 0;
    for (int k = 0; k < 99 && !done; k++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        done = 1;
      end
    end
    hang(done);
  endtask
  task pulse;
    @(posedge clk_sys);
    sysrefEdge <= 1;
    @(posedge clk_sys);
    sysrefEdge <= 0;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  initial begin
    wait_n(8);
    rst_n <= 1;
    chk(thresholdAlarmPin, 0);
    chk(irq, 0);
    for (i = 0; i < 9; i++) begin
      rd(tbl[i][35:24]);
      chk(v, tbl[i][23:16]);
      wr(tbl[i][35:24], tbl[i][15:8]);
      rd(tbl[i][35:24]);
      chk(v, tbl[i][7:0]);
    end
    wr(12'h300, 8'h01);
    chk(r, `RESP_SLVERR);
    rd(12'h300);
    chk(r, `RESP_SLVERR);
    chk(v, 32'h0);
    for (i = 0; i < 10; i++) wr(cfg[i][19:8], cfg[i][7:0]);
    wr(`IDX_FD_CTRL, 8'h01);
    magnitude <= 13'h164;
    wait_n(4);
    chk(thresholdAlarmPin, 0);
    magnitude <= 13'h165;
    wait_n(4);
    chk(thresholdAlarmPin, 1);
    magnitude <= 13'h131;
    wait_n(3);
    chk(thresholdAlarmPin, 1);
    wait_n(3);
    chk(thresholdAlarmPin, 0);
    chk(nRise, 1);
    chk(irq, 1);
    wr(`IDX_IRQ_STAT, 8'h01);
    wait_n(2);
    chk(irq, 0);
    wr(`IDX_FD_CTRL, 8'h0d);
    wait_n(3);
    chk(thresholdAlarmPin, 1);
    magnitude <= 13'h1fff;
    wr(`IDX_FD_CTRL, 8'h09);
    wait_n(3);
    chk(thresholdAlarmPin, 0);
    for (i = 0; i < 3; i++) begin
      if (i == 2) wait_n(120);
      rd(`IDX_FRAME);
      f[i] = v[7:0];
    end
    d = f[2] - f[1] - f[1] + f[0];
    chk(d >= 59 && d <= 61, 1);
    wr(`IDX_SYNC, 8'h01);
    pulse;
    rd(`IDX_SYNC);
    chk(v, 1);
    sysrefEnabled <= 1;
    pulse;
    rd(`IDX_SYNC);
    chk(v, 0);
    rd(`IDX_IRQ_STAT);
    chk(v[2], 1);
    wr(`IDX_IRQ_STAT, 8'h04);
    pulse;
    rd(`IDX_IRQ_STAT);
    chk(v[2], 0);
    magnitude <= 13'h0abc;
    wait_n(10);
    wr(`IDX_STCTL, 8'h11);
    rd(`IDX_ST0);
    chk(v, 8'hbc);
    rd(`IDX_STCTL);
    chk(v, 1);
    wr(`IDX_MONCTL, 8'h00);
    magnitude <= 13'h0fff;
    wait_n(10);
    wr(`IDX_STCTL, 8'h11);
    rd(`IDX_ST1);
    chk(v, 8'h0a);
    give_verdict;
  end
endmodule // fdet_mon_tb
bind fdet_mon fdet_mon_properties i_chk (.clk_sys, .rst_n, .thresholdAlarmPin, .irq, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready);
